/* File: src/aogt_trim_bank.v */
// apb register bank holding converter offset and fine gain trims
`timescale 1ns/1ns
`include "aogt_regs.vh"
module aogt_trim_bank
(
  input  wire        mclk,
  input  wire        rst,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output reg         pready,
  output reg         pslverr,
  output reg         fuse_rd,
  output reg  [3:0]  fuse_addr,
  input  wire [15:0] fuse_data,
  input  wire        offset_cal_busy,
  input  wire        core2_sel_inb,
  input  wire        core3_sel_ind,
  output reg  [11:0] core2_inb_offset_word,
  output reg         core2_inb_offset_use,
  output reg  [11:0] core3_offset_applied,
  output reg  [11:0] core4_offset_word,
  output reg  [11:0] core5_offset_word,
  output reg  [4:0]  core0_gain_trim,
  output reg  [4:0]  core1_gain_trim,
  output reg  [4:0]  core2_gain_applied,
  output reg         trim_ready
);

  // ----------------------------------------------------------------
  // fuse loader states
  // ----------------------------------------------------------------
  localparam LD_IDLE = 2'b00;
  localparam LD_REQ  = 2'b01;
  localparam LD_CAPT = 2'b10;
  localparam LD_DONE = 2'b11;

  reg  [1:0]  ld_state;
  reg  [1:0]  next_ld_state;
  reg  [3:0]  ld_slot;
  reg  [3:0]  next_ld_slot;
  reg         cal_err;
  reg  [31:0] next_prdata;
  reg         next_pslverr;
  reg  [8:0]  hit;
  wire [9:0]  idx;
  wire        access_end;
  wire        wr_go;
  wire        ofs_hit;
  wire        ctrl_reload;
  wire        sta_clear;
  wire        loaded;
  wire        reload_req;

  // per-register values and strobes
  wire [15:0] ofs_val [0:4];
  wire [7:0]  gain_val [0:3];
  wire [8:0]  ld_hit;

  // ----------------------------------------------------------------
  // address decode
  // ----------------------------------------------------------------
  // byte offset within a word is ignored; each register owns one word
  assign idx        = paddr[11:2];
  assign access_end = psel & penable & pready;
  assign wr_go      = access_end & pwrite;
  assign ofs_hit    = |hit[4:0];
  assign loaded     = (ld_state == LD_DONE);

  // one-hot match of the word index against the trim registers
  always @*
  begin
    hit    = 9'h000;
    hit[0] = (idx == `AOGT_IDX_C2B_OFS);
    hit[1] = (idx == `AOGT_IDX_C3C_OFS);
    hit[2] = (idx == `AOGT_IDX_C3D_OFS);
    hit[3] = (idx == `AOGT_IDX_C4_OFS);
    hit[4] = (idx == `AOGT_IDX_C5_OFS);
    hit[5] = (idx == `AOGT_IDX_C0_GAIN);
    hit[6] = (idx == `AOGT_IDX_C1_GAIN);
    hit[7] = (idx == `AOGT_IDX_C2A_GAIN);
    hit[8] = (idx == `AOGT_IDX_C2B_GAIN);
  end

  // ----------------------------------------------------------------
  // control and status strobes
  // ----------------------------------------------------------------
  // a reload is honoured only once the running load is complete
  assign ctrl_reload = wr_go & (idx == `AOGT_IDX_CTRL) & pwdata[`AOGT_CTRL_RELOAD];
  assign sta_clear   = wr_go & (idx == `AOGT_IDX_STATUS) & pwdata[`AOGT_STA_CALERR];
  assign reload_req  = ctrl_reload & loaded;

  // ----------------------------------------------------------------
  // trim registers
  // ----------------------------------------------------------------
  // offset words: fuse slots 0 to 4
  genvar gi;
  generate
    for (gi = 0; gi < `AOGT_NUM_OFS; gi = gi + 1)
    begin : g_ofs
      assign ld_hit[gi] = (ld_state == LD_CAPT) && (ld_slot == gi);
      aogt_trim_reg #(.W(`AOGT_OFS_W)) u_ofs
      (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_go & hit[gi]),
        .ld_en   (ld_hit[gi]),
        .wr_data (pwdata[15:0]),
        .ld_data (fuse_data),
        .value   (ofs_val[gi])
      );
    end
    // gain words: fuse slots 5 to 8, low byte of the fuse word
    for (gi = 0; gi < `AOGT_NUM_GAIN; gi = gi + 1)
    begin : g_gain
      assign ld_hit[gi+5] = (ld_state == LD_CAPT) && (ld_slot == gi + 5);
      aogt_trim_reg #(.W(`AOGT_GAIN_W)) u_gain
      (
        .mclk    (mclk),
        .rst     (rst),
        .wr_en   (wr_go & hit[gi+5]),
        .ld_en   (ld_hit[gi+5]),
        .wr_data (pwdata[7:0]),
        .ld_data (fuse_data[7:0]),
        .value   (gain_val[gi])
      );
    end
  endgenerate

  // ----------------------------------------------------------------
  // fuse loader
  // ----------------------------------------------------------------
  // walks every fuse slot after reset, and again on a reload request;
  // the bus is held off meanwhile so no write can race a load
  always @*
  begin
    next_ld_state = ld_state;
    next_ld_slot  = ld_slot;
    case (ld_state)
      LD_IDLE:
      begin
        next_ld_state = LD_REQ;
        next_ld_slot  = 4'h0;
      end
      LD_REQ:
      begin
        next_ld_state = LD_CAPT;
      end
      LD_CAPT:
      begin
        if (ld_slot == `AOGT_LAST_SLOT)
          next_ld_state = LD_DONE;
        else
        begin
          next_ld_state = LD_REQ;
          next_ld_slot  = ld_slot + 4'h1;
        end
      end
      LD_DONE:
      begin
        if (reload_req)
        begin
          next_ld_state = LD_REQ;
          next_ld_slot  = 4'h0;
        end
      end
      default:
      begin
        next_ld_state = LD_IDLE;
        next_ld_slot  = 4'h0;
      end
    endcase
  end

  // loader state registers
  always @(posedge mclk)
  begin
    if (rst)
    begin
      ld_state <= LD_IDLE;
      ld_slot  <= 4'h0;
    end
    else
    begin
      ld_state <= next_ld_state;
      ld_slot  <= next_ld_slot;
    end
  end

  // ----------------------------------------------------------------
  // fuse port and load status
  // ----------------------------------------------------------------
  // decoded from the next state so each output leaves a flop; the fuse word
  // must be valid in the cycle after the strobe, when the slot is captured
  always @(posedge mclk)
  begin
    if (rst)
    begin
      fuse_rd    <= 1'b0;
      fuse_addr  <= 4'h0;
      trim_ready <= 1'b0;
    end
    else
    begin
      fuse_rd    <= (next_ld_state == LD_REQ);
      fuse_addr  <= next_ld_slot;
      trim_ready <= (next_ld_state == LD_DONE);
    end
  end

  // ----------------------------------------------------------------
  // calibration access flag
  // ----------------------------------------------------------------
  // software must keep off offset words during offset calibration; the
  // bank still completes such an access but records it. set wins over clear
  always @(posedge mclk)
  begin
    if (rst)
      cal_err <= 1'b0;
    else if (access_end & ofs_hit & offset_cal_busy)
      cal_err <= 1'b1;
    else if (sta_clear)
      cal_err <= 1'b0;
  end

  // ----------------------------------------------------------------
  // read mux
  // ----------------------------------------------------------------
  // reserved bits read back as stored; unused upper bits read zero
  always @*
  begin
    next_prdata  = 32'h0000_0000;
    next_pslverr = 1'b0;
    case (idx)
      `AOGT_IDX_C2B_OFS:  next_prdata[15:0] = ofs_val[0];
      `AOGT_IDX_C3C_OFS:  next_prdata[15:0] = ofs_val[1];
      `AOGT_IDX_C3D_OFS:  next_prdata[15:0] = ofs_val[2];
      `AOGT_IDX_C4_OFS:   next_prdata[15:0] = ofs_val[3];
      `AOGT_IDX_C5_OFS:   next_prdata[15:0] = ofs_val[4];
      `AOGT_IDX_C0_GAIN:  next_prdata[7:0]  = gain_val[0];
      `AOGT_IDX_C1_GAIN:  next_prdata[7:0]  = gain_val[1];
      `AOGT_IDX_C2A_GAIN: next_prdata[7:0]  = gain_val[2];
      `AOGT_IDX_C2B_GAIN: next_prdata[7:0]  = gain_val[3];
      `AOGT_IDX_CTRL:     next_prdata       = 32'h0000_0000;  // reload self-clears
      `AOGT_IDX_STATUS:
      begin
        next_prdata[`AOGT_STA_DONE]    = loaded;
        next_prdata[`AOGT_STA_CALBUSY] = offset_cal_busy;
        next_prdata[`AOGT_STA_CALERR]  = cal_err;
      end
      default:            next_pslverr      = 1'b1;
    endcase
  end

  // ----------------------------------------------------------------
  // apb answer
  // ----------------------------------------------------------------
  // one wait state in the access phase; more while fuses are loading
  always @(posedge mclk)
  begin
    if (rst)
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
    else if (psel & penable & ~pready & loaded)
    begin
      pready  <= 1'b1;
      prdata  <= pwrite ? 32'h0000_0000 : next_prdata;
      pslverr <= next_pslverr;
    end
    else
    begin
      pready  <= 1'b0;
      prdata  <= 32'h0000_0000;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // fixed offset trims toward the analog datapath
  // ----------------------------------------------------------------
  // fields are passed as plain unsigned codes; a new value reaches the
  // cores one cycle after the write or load, with no commit step
  always @(posedge mclk)
  begin
    if (rst)
    begin
      core2_inb_offset_word <= 12'h000;
      core4_offset_word     <= 12'h000;
      core5_offset_word     <= 12'h000;
    end
    else
    begin
      core2_inb_offset_word <= ofs_val[0][`AOGT_OFS_MSB:0];
      core4_offset_word     <= ofs_val[3][`AOGT_OFS_MSB:0];
      core5_offset_word     <= ofs_val[4][`AOGT_OFS_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // input-dependent trims
  // ----------------------------------------------------------------
  // the selects are registered in step with the words they pick, so a core
  // never sees the word of one input paired with the flag of the other
  always @(posedge mclk)
  begin
    if (rst)
    begin
      core2_inb_offset_use <= 1'b0;
      core3_offset_applied <= 12'h000;
      core2_gain_applied   <= 5'h00;
    end
    else
    begin
      core2_inb_offset_use <= core2_sel_inb;
      core3_offset_applied <= core3_sel_ind ?
                              ofs_val[2][`AOGT_OFS_MSB:0] :
                              ofs_val[1][`AOGT_OFS_MSB:0];
      core2_gain_applied   <= core2_sel_inb ?
                              gain_val[3][`AOGT_GAIN_MSB:0] :
                              gain_val[2][`AOGT_GAIN_MSB:0];
    end
  end

  // ----------------------------------------------------------------
  // fixed gain trims
  // ----------------------------------------------------------------
  // only the low five bits leave the bank; reserved bits stay in the store
  always @(posedge mclk)
  begin
    if (rst)
    begin
      core0_gain_trim <= 5'h00;
      core1_gain_trim <= 5'h00;
    end
    else
    begin
      core0_gain_trim <= gain_val[0][`AOGT_GAIN_MSB:0];
      core1_gain_trim <= gain_val[1][`AOGT_GAIN_MSB:0];
    end
  end

endmodule // aogt_trim_bank

/* File: src/aogt_regs.vh */
// constants for the converter trim register bank
//
// Notes on behaviour
// - core 4 offset word in bits 11:0
// - core 5 offset word in bits 11:0
// - core 2 input B own offset word
// - core 3 picks offset by input C/D
// - core 0 gain trim in bits 4:0
// - core 1 gain trim in bits 4:0
// - core 2 gain differs for inputs A/B
// - trims default from fuse memory after reset
// - offset fields are unsigned binary
`ifndef AOGT_REGS_VH
`define AOGT_REGS_VH

// ----------------------------------------------------------------
// register indices (byte address is four times the index)
// ----------------------------------------------------------------
`define AOGT_IDX_C2B_OFS   10'h336
`define AOGT_IDX_C3C_OFS   10'h338
`define AOGT_IDX_C3D_OFS   10'h33a
`define AOGT_IDX_C4_OFS    10'h33c
`define AOGT_IDX_C5_OFS    10'h33e
`define AOGT_IDX_C0_GAIN   10'h360
`define AOGT_IDX_C1_GAIN   10'h361
`define AOGT_IDX_C2A_GAIN  10'h362
`define AOGT_IDX_C2B_GAIN  10'h363
`define AOGT_IDX_CTRL      10'h370
`define AOGT_IDX_STATUS    10'h371

// ----------------------------------------------------------------
// widths, fields and reset values
// ----------------------------------------------------------------
`define AOGT_OFS_W         16
`define AOGT_GAIN_W        8
`define AOGT_OFS_MSB       11
`define AOGT_GAIN_MSB      4
`define AOGT_OFS_RST       16'h0000
`define AOGT_GAIN_RST      8'h00
`define AOGT_NUM_OFS       5
`define AOGT_NUM_GAIN      4
`define AOGT_NUM_TRIM      9
`define AOGT_LAST_SLOT     4'h8
`define AOGT_CTRL_RELOAD   0
`define AOGT_STA_DONE      0
`define AOGT_STA_CALBUSY   1
`define AOGT_STA_CALERR    2

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define AOGT_CLK_NS        20

`endif

/* File: src/aogt_trim_reg.v */
// one trim register: bus write, fuse load, constant reset
`timescale 1ns/1ns
module aogt_trim_reg
#(
  parameter W = 16
)
(
  input  wire         mclk,
  input  wire         rst,
  input  wire         wr_en,
  input  wire         ld_en,
  input  wire [W-1:0] wr_data,
  input  wire [W-1:0] ld_data,
  output reg  [W-1:0] value
);

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  // the fuse load and the bus never overlap: the bus stalls while loading
  always @(posedge mclk)
  begin
    if (rst)
      value <= {W{1'b0}};
    else if (ld_en)
      value <= ld_data;
    else if (wr_en)
      value <= wr_data;  // reserved bits stored as written
  end

endmodule // aogt_trim_reg

/* File: sim/aogt_trim_bank_monitor.sv */
// port-level assertion checker for the trim register bank
`timescale 1ns/1ns
module aogt_trim_bank_monitor
(
  input wire        mclk,
  input wire        rst,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  input wire        pready,
  input wire        pslverr,
  input wire        trim_ready,
  input wire        core2_sel_inb,
  input wire        core3_sel_ind,
  input wire [11:0] core2_inb_offset_word,
  input wire [11:0] core3_offset_applied,
  input wire [11:0] core4_offset_word,
  input wire [11:0] core5_offset_word,
  input wire [4:0]  core0_gain_trim,
  input wire [4:0]  core1_gain_trim,
  input wire [4:0]  core2_gain_applied
);
  // ----------------------------------------------------------------
  // accepted writes
  // ----------------------------------------------------------------
  wire [9:0] ix = paddr[11:2];
  // two edges allow for the output flop behind the register
  wire       wr = psel && penable && pready && pwrite && !pslverr;
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  a_core4_offset_trim_write:
    assert property (wr && ix == 10'h33c |-> ##2 core4_offset_word == $past(pwdata[11:0], 2))
    else $error("core 4 offset not applied");
  a_core5_offset_trim_write:
    assert property (wr && ix == 10'h33e |-> ##2 core5_offset_word == $past(pwdata[11:0], 2))
    else $error("core 5 offset not applied");
  a_inb_ofs_write:
    assert property (wr && ix == 10'h336 |-> ##2
      core2_inb_offset_word == $past(pwdata[11:0], 2)) else $error("core 2 b offset wrong");
  a_core3_sel:
    assert property (wr && ix == 10'h338 && !core3_sel_ind ##1 !core3_sel_ind |=>
      core3_offset_applied == $past(pwdata[11:0], 2)) else $error("core 3 c offset wrong");
  a_core0_fine_gain_write:
    assert property (wr && ix == 10'h360 |-> ##2 core0_gain_trim == $past(pwdata[4:0], 2))
    else $error("core 0 gain not applied");
  a_core1_fine_gain_write:
    assert property (wr && ix == 10'h361 |-> ##2 core1_gain_trim == $past(pwdata[4:0], 2))
    else $error("core 1 gain not applied");
  a_gain2_sel:
    assert property (wr && ix == 10'h362 && !core2_sel_inb ##1 !core2_sel_inb |=>
      core2_gain_applied == $past(pwdata[4:0], 2)) else $error("core 2 a gain wrong");
  a_reset_clear:
    assert property ($fell(rst) |-> core4_offset_word == 12'h000 && !trim_ready)
    else $error("trims not cleared by reset");
  a_stall_load:
    assert property (!trim_ready |-> !pready) else $error("bus answered before fuse load");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held past one cycle");
endmodule // aogt_trim_bank_monitor

bind aogt_trim_bank aogt_trim_bank_monitor mon_i (.mclk, .rst, .psel, .penable, .pwrite,
  .paddr, .pwdata, .pready, .pslverr, .trim_ready, .core2_sel_inb, .core3_sel_ind,
  .core2_inb_offset_word, .core3_offset_applied, .core4_offset_word, .core5_offset_word,
  .core0_gain_trim, .core1_gain_trim, .core2_gain_applied);

/* File: sim/tb_top.sv */
// self-checking testbench for the trim register bank
`timescale 1ns/1ns
module tb_top;
  reg         mclk = 1'b0;
  reg         rst = 1'b1;
  reg         psel = 1'b0;
  reg         penable = 1'b0;
  reg         pwrite = 1'b0;
  reg  [11:0] paddr = 12'h000;
  reg  [31:0] pwdata = 32'h0;
  reg  [15:0] fuse_data = 16'h0000;
  reg         offset_cal_busy = 1'b0;
  reg         core2_sel_inb = 1'b0;
  reg         core3_sel_ind = 1'b0;
  wire [31:0] prdata;
  wire        pready, pslverr, fuse_rd, core2_inb_offset_use, trim_ready;
  wire [3:0]  fuse_addr;
  wire [11:0] core2_inb_offset_word, core3_offset_applied;
  wire [11:0] core4_offset_word, core5_offset_word;
  wire [4:0]  core0_gain_trim, core1_gain_trim, core2_gain_applied;
  integer     err_count = 0;
  integer     total_checks = 0;
  integer     i;
  reg  [31:0] rd;
  reg         er;
  reg  [31:0] v;

  always #10 mclk = ~mclk;
  // fuse word is valid only in the cycle after the strobe, garbage otherwise
  always @(posedge mclk)
    fuse_data <= fuse_rd ? 16'h0a50 + {12'h000, fuse_addr} : ~fuse_data;

  aogt_trim_bank aogt_trim_bank_i (.mclk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .fuse_rd, .fuse_addr, .fuse_data, .offset_cal_busy,
    .core2_sel_inb, .core3_sel_ind, .core2_inb_offset_word, .core2_inb_offset_use,
    .core3_offset_applied, .core4_offset_word, .core5_offset_word, .core0_gain_trim,
    .core1_gain_trim, .core2_gain_applied, .trim_ready);

  // ----------------------------------------------------------------
  // shared tasks
  // ----------------------------------------------------------------
  task test_done;
    begin
      $display("checks %0d errors %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0)
        $display("TEST PASSED");
      else
        $display("TEST FAILED");
      $finish;
    end
  endtask

  task chk(input string nm, input reg [31:0] e, input reg [31:0] s);
    begin
      total_checks = total_checks + 1;
      if (s !== e)
      begin
        err_count = err_count + 1;
        $display("[ERR] %s exp %h got %h", nm, e, s);
      end
    end
  endtask

  task tick(input integer c);
    repeat (c) @(posedge mclk);
  endtask

  // bounded wait on a flag; running out ends the run
  task wait_load;
    integer k;
    begin
      k = 0;
      while (trim_ready !== 1'b1 && k < 100)
      begin
        k = k + 1;
        @(posedge mclk);
      end
      if (trim_ready !== 1'b1)
      begin
        chk("trim_ready", 32'h1, {31'h0, trim_ready});
        test_done;
      end
      tick(1);
    end
  endtask

  // one apb transfer; request held until pready is seen at an edge
  task xfer(input reg w, input reg [11:0] a, input reg [31:0] d);
    integer k;
    begin
      @(posedge mclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge mclk);
      penable <= 1'b1;
      k = 0;
      @(posedge mclk);
      while (pready !== 1'b1 && k < 60)
      begin
        k = k + 1;
        @(posedge mclk);
      end
      if (pready !== 1'b1)
      begin
        chk("pready", 32'h1, {31'h0, pready});
        test_done;
      end
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
    end
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial
  begin
    tick(12);
    rst <= 1'b0;
    wait_load;
    chk("c4 fuse", 32'h0a53, {20'h0, core4_offset_word});
    chk("c0 fuse", 32'h15, {27'h0, core0_gain_trim});
    // offsets then gains, reserved bits kept zero, offsets fff down to bbb, gains 1a down to 17
    for (i = 0; i < 9; i = i + 1)
    begin
      v = i < 5 ? 32'hfff - 32'h111 * i : 32'h1f - i;
      xfer(1'b1, 12'(i < 5 ? 12'hcd8 + 8 * i : 12'hd80 + 4 * (i - 5)), v);
      xfer(1'b0, 12'(i < 5 ? 12'hcd8 + 8 * i : 12'hd80 + 4 * (i - 5)), 32'h0);
      chk("readback", v, rd);
    end
    tick(3);
    chk("c2b ofs", 32'hfff, {20'h0, core2_inb_offset_word});
    chk("c3 ofs c", 32'heee, {20'h0, core3_offset_applied});
    chk("c4 ofs", 32'hccc, {20'h0, core4_offset_word});
    chk("c5 ofs", 32'hbbb, {20'h0, core5_offset_word});
    chk("c0 gain", 32'h1a, {27'h0, core0_gain_trim});
    chk("c1 gain", 32'h19, {27'h0, core1_gain_trim});
    chk("c2 gain a", 32'h18, {27'h0, core2_gain_applied});
    core3_sel_ind <= 1'b1;
    core2_sel_inb <= 1'b1;
    tick(3);
    chk("c3 ofs d", 32'hddd, {20'h0, core3_offset_applied});
    chk("c2 gain b", 32'h17, {27'h0, core2_gain_applied});
    chk("c2b use", 32'h1, {31'h0, core2_inb_offset_use});
    // unmapped places answer with an error and read zero
    xfer(1'b0, 12'h000, 32'h0);
    chk("unmapped rd", 32'h1, {31'h0, er});
    chk("unmapped data", 32'h0, rd);
    xfer(1'b1, 12'h004, 32'h5);
    chk("unmapped wr", 32'h1, {31'h0, er});
    // a second reset brings the fuse defaults back over software values
    rst <= 1'b1;
    tick(2);
    rst <= 1'b0;
    wait_load;
    chk("c4 refuse", 32'h0a53, {20'h0, core4_offset_word});
    // software value, live status, then a reload brings the fuse default back
    xfer(1'b1, 12'hcf0, 32'h321);
    tick(3);
    chk("c4 sw", 32'h321, {20'h0, core4_offset_word});
    offset_cal_busy <= 1'b1;
    xfer(1'b0, 12'hdc4, 32'h0);
    chk("status", 32'h3, rd);
    offset_cal_busy <= 1'b0;
    xfer(1'b1, 12'hdc0, 32'h1);
    tick(1);
    wait_load;
    chk("c4 reload", 32'h0a53, {20'h0, core4_offset_word});
    test_done;
  end
endmodule // tb_top
